// ==== dlp_defines.vh ====
// Shared constants for the DDR3 low-power sequencer.
`ifndef DLP_DEFINES_VH
`define DLP_DEFINES_VH
// Command encodings {cs_n, ras_n, cas_n, we_n}.
`define DLP_CMD_NOP 4'h7
`define DLP_CMD_DES 4'hF
`define DLP_CMD_REF 4'h1
`define DLP_CMD_SRE 4'h1
// Default cycle counts at 10 MHz (100 ns clock).
`define DLP_T_CKE 8'h03
`define DLP_T_CKESR 8'h04
`define DLP_T_CPDED 8'h01
`define DLP_T_XP 8'h03
`define DLP_T_XPDLL 8'h18
`define DLP_T_XS 8'h03
`define DLP_T_XSDLL 16'h0200
`define DLP_T_CKSRE 8'h01
`define DLP_T_CKSRX 8'h01
`define DLP_T_RFC 8'h03
`define DLP_T_VREF 16'h0200
`define DLP_PD_MAX 32'h00001E00
`endif

// ==== dlp_down_cnt.v ====
// Loadable down-counter with a done flag.
`timescale 1ns/100ps
module dlp_down_cnt #(
   parameter W = 16
) (
   input wire i_sys_clk, // System clock.
   input wire i_nrst, // Asynchronous reset, active low.
   input wire i_load, // Load pulse.
   input wire [W-1:0] i_val, // Count to load.
   output wire o_done // High when the count reached zero.
);
   reg [W-1:0] cnt_q; // Remaining cycles.
   ////////////////////////////////////////////////////////////////////////
   // Count down after a load, hold at zero.
   always @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cnt_q <= {W{1'b0}};
      end else if (i_load) begin
         cnt_q <= i_val;
      end else if (cnt_q != {W{1'b0}}) begin
         cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
      end
   end
   assign o_done = (cnt_q == {W{1'b0}});
endmodule

// ==== dlp_sync3.v ====
// Three-stage synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/100ps
module dlp_sync3 (
   input wire i_sys_clk, // System clock.
   input wire i_nrst, // Asynchronous reset, active low.
   input wire i_async, // Input from another domain.
   output reg o_sync // Filtered synchronous level.
);
   reg s1_q; // First stage, read only by the second.
   reg s2_q; // Second stage.
   reg s3_q; // Third stage.
   ////////////////////////////////////////////////////////////////////////
   // Shift and accept the level when two and three agree.
   always @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         o_sync <= 1'b0;
      end else begin
         s1_q <= i_async;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            o_sync <= s3_q;
         end
      end
   end
endmodule

// ==== dlp_lowpower_ctrl.v ====
// Host-side DDR3 self-refresh and power-down sequencer.
//
// Contract
// - Self-refresh entry: CS RAS CAS CKE low, WE high.
// - Enter self-refresh only when idle, precharged.
// - ODT off before self-refresh entry.
// - Keep CKE low throughout self-refresh.
// - First write 512 cycles after exit if VREF floated.
// - Stay in self-refresh at least tCKESR.
// - Clock stop after tCKSRE, stable tCKSRX before exit.
// - Exit with NOP; wait tXS, then tXSDLL.
// - CKE high through tXSDLL unless refresh then re-entry.
// - Only NOP during tXS; ODT off in tXSDLL.
// - Power-down entry: CKE low with NOP.
// - No CKE drop during MRS, ZQ, read, write.
// - Reset DLL after power-down entered unlocked.
// - Drive NOP during tCPDED after CKE drop.
// - Wait tXP, or tXPDLL after slow exit.
// - Hold each CKE level at least tCKE.
// - Power-down lasts at most nine refresh intervals.
// - Early entry after refresh: NOP until tRFC.
`timescale 1ns/100ps
`include "dlp_defines.vh"
module dlp_lowpower_ctrl #(
   parameter [15:0] T_XSDLL = `DLP_T_XSDLL, // Self-refresh DLL exit wait.
   parameter [15:0] T_VREF = `DLP_T_VREF, // Write block after float.
   parameter [31:0] PD_MAX = `DLP_PD_MAX // Longest power-down in cycles.
) (
   input wire i_sys_clk, // 10 MHz system clock.
   input wire i_nrst, // Asynchronous reset, active low.
   input wire i_sr_req, // Level: request self-refresh.
   input wire i_pd_req, // Level: request power-down.
   input wire i_idle, // Device idle and precharged, tRP met.
   input wire i_busy, // MRS, MPR, ZQ, DLL lock or burst active.
   input wire i_odt_off, // ODT already disabled for entry.
   input wire i_slow_exit, // Power-down will use slow exit.
   input wire i_dll_unlocked, // DLL was not locked at entry.
   input wire i_vref_float, // VREFDQ floated in self-refresh.
   input wire i_ref_recent, // A refresh lies within tRFC.
   input wire i_clk_stable, // Asynchronous: memory clock is stable.
   input wire i_cmd_valid, // User command request.
   input wire [3:0] i_cmd, // User command {cs,ras,cas,we} low-true.
   input wire i_cmd_is_wr, // User command is a write or leveling.
   input wire i_cmd_need_dll, // User command needs a locked DLL.
   output wire o_cmd_ready, // User command accepted this cycle.
   output reg o_cke, // CKE pin.
   output reg o_cs_n, // Chip select, active low.
   output reg o_ras_n, // Row strobe, active low.
   output reg o_cas_n, // Column strobe, active low.
   output reg o_we_n, // Write enable, active low.
   output reg o_odt_en_n, // Low lets the user drive ODT.
   output reg o_clk_stop_ok, // Memory clock may be stopped.
   output reg o_dll_reset_req, // Pulse: issue DLL reset now.
   output reg o_need_refresh, // Refresh required before re-entry.
   output wire o_in_sr, // Device is in self-refresh.
   output wire o_in_pd // Device is in power-down.
);
   ////////////////////////////////////////////////////////////////////////
   // State codes, one-hot.
   localparam [6:0] ST_RUN = 7'h01;
   localparam [6:0] ST_SRE = 7'h02;
   localparam [6:0] ST_SR = 7'h04;
   localparam [6:0] ST_SRX = 7'h08;
   localparam [6:0] ST_PDE = 7'h10;
   localparam [6:0] ST_PD = 7'h20;
   localparam [6:0] ST_PDX = 7'h40;

   reg [6:0] st_q; // Current state.
   reg [6:0] st_d; // Next state.
   reg ld_a; // Load primary timer.
   reg [15:0] val_a; // Primary timer value.
   reg ld_b; // Load DLL timer.
   reg [15:0] val_b; // DLL timer value.
   reg ld_w; // Load write-block timer.
   reg ld_r; // Load refresh-hold timer.
   reg [31:0] pd_cnt_q; // Power-down residency counter.
   reg slow_q; // Last power-down used slow exit.
   reg dllu_q; // DLL was unlocked at power-down entry.
   reg early_q; // Power-down entered soon after refresh.
   wire done_a; // Primary wait elapsed.
   wire done_b; // DLL wait elapsed.
   wire done_w; // Write block elapsed.
   wire done_r; // Refresh hold elapsed.
   wire clk_ok; // Synchronised clock-stable level.

   ////////////////////////////////////////////////////////////////////////
   // Timers and synchroniser.
   dlp_down_cnt #(.W(16)) u_ta (
      .i_sys_clk(i_sys_clk),
      .i_nrst(i_nrst),
      .i_load(ld_a),
      .i_val(val_a),
      .o_done(done_a)
   );
   dlp_down_cnt #(.W(16)) u_tb (
      .i_sys_clk(i_sys_clk),
      .i_nrst(i_nrst),
      .i_load(ld_b),
      .i_val(val_b),
      .o_done(done_b)
   );
   dlp_down_cnt #(.W(16)) u_tw (
      .i_sys_clk(i_sys_clk),
      .i_nrst(i_nrst),
      .i_load(ld_w),
      .i_val(T_VREF),
      .o_done(done_w)
   );
   dlp_down_cnt #(.W(16)) u_tr (
      .i_sys_clk(i_sys_clk),
      .i_nrst(i_nrst),
      .i_load(ld_r),
      .i_val({8'h00, `DLP_T_RFC}),
      .o_done(done_r)
   );
   dlp_sync3 u_clk_sync (
      .i_sys_clk(i_sys_clk),
      .i_nrst(i_nrst),
      .i_async(i_clk_stable),
      .o_sync(clk_ok)
   );

   assign o_in_sr = (st_q == ST_SR);
   assign o_in_pd = (st_q == ST_PD);

   // User commands pass only in normal run when every gate is open.
   assign o_cmd_ready = (st_q == ST_RUN) && i_cmd_valid && done_a &&
      done_r && (!i_cmd_need_dll || done_b) &&
      (!i_cmd_is_wr || done_w) &&
      !(i_sr_req || i_pd_req);

   ////////////////////////////////////////////////////////////////////////
   // Next-state and timer-load logic.
   always @* begin
      st_d = st_q;
      ld_a = 1'b0;
      val_a = 16'h0000;
      ld_b = 1'b0;
      val_b = 16'h0000;
      ld_w = 1'b0;
      ld_r = 1'b0;
      case (st_q)
         ST_RUN: begin
            // Self-refresh entry waits for idleness, power-down for !i_busy; both wait for exit windows; power-down does not wait for the tRFC hold.
            if (done_a && done_b && done_r && i_sr_req && i_idle &&
               i_odt_off && !o_need_refresh) begin
               st_d = ST_SRE;
               ld_a = 1'b1;
               val_a = {8'h00, `DLP_T_CKSRE};
            end else if (done_a && done_b && i_pd_req && !i_busy &&
               !i_sr_req) begin
               st_d = ST_PDE;
               ld_a = 1'b1;
               val_a = {8'h00, `DLP_T_CPDED};
            end
         end
         ST_SRE: begin
            // Self-refresh entry issued; wait before the clock may stop.
            if (done_a) begin
               st_d = ST_SR;
               ld_a = 1'b1;
               val_a = {8'h00, `DLP_T_CKESR};
            end
         end
         ST_SR: begin
            // Exit only after tCKESR with a clock stable for tCKSRX.
            if (!i_sr_req && done_a && clk_ok) begin
               st_d = ST_SRX;
               ld_a = 1'b1;
               val_a = {8'h00, `DLP_T_XS};
               ld_b = 1'b1;
               val_b = T_XSDLL;
               ld_w = i_vref_float;
            end
         end
         ST_SRX: begin
            // Only NOP during tXS.
            if (done_a) begin
               st_d = ST_RUN;
            end
         end
         ST_PDE: begin
            // NOP through tCPDED, then hold CKE low at least tCKE.
            if (done_a) begin
               st_d = ST_PD;
               ld_a = 1'b1;
               val_a = {8'h00, `DLP_T_CKE};
            end
         end
         ST_PD: begin
            // Leave on request or at the residency limit.
            if (done_a && (!i_pd_req || pd_cnt_q >= PD_MAX)) begin
               st_d = ST_PDX;
               ld_a = 1'b1;
               val_a = {8'h00, `DLP_T_CKE};
            end
         end
         ST_PDX: begin
            // CKE high held tCKE, then tXP and perhaps tXPDLL.
            if (done_a) begin
               st_d = ST_RUN;
               ld_a = 1'b1;
               val_a = {8'h00, `DLP_T_XP};
               ld_b = slow_q;
               val_b = {8'h00, `DLP_T_XPDLL};
               ld_r = early_q;
            end
         end
         default: begin
            st_d = ST_RUN;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // State and bookkeeping registers.
   always @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st_q <= ST_RUN;
         pd_cnt_q <= 32'h00000000;
         slow_q <= 1'b0;
         dllu_q <= 1'b0;
         early_q <= 1'b0;
         o_need_refresh <= 1'b0;
         o_dll_reset_req <= 1'b0;
      end else begin
         st_q <= st_d;
         o_dll_reset_req <= 1'b0;
         if (st_q == ST_PD) begin
            pd_cnt_q <= pd_cnt_q + 32'h00000001;
         end else begin
            pd_cnt_q <= 32'h00000000;
         end
         if (st_q == ST_RUN && st_d == ST_PDE) begin
            slow_q <= i_slow_exit;
            dllu_q <= i_dll_unlocked;
            early_q <= i_ref_recent;
         end
         if (st_q == ST_PDX && st_d == ST_RUN) begin
            o_dll_reset_req <= dllu_q;
         end
         // Set on exit wins over a refresh in the same cycle.
         if (st_q == ST_SRX && st_d == ST_RUN) begin
            o_need_refresh <= 1'b1;
         end else if (o_cmd_ready && i_cmd == `DLP_CMD_REF) begin
            o_need_refresh <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin drivers, registered from the next state.
   always @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_cke <= 1'b0;
         {o_cs_n, o_ras_n, o_cas_n, o_we_n} <= `DLP_CMD_DES;
         o_odt_en_n <= 1'b1;
         o_clk_stop_ok <= 1'b0;
      end else begin
         o_cke <= 1'b1;
         {o_cs_n, o_ras_n, o_cas_n, o_we_n} <= `DLP_CMD_NOP;
         o_odt_en_n <= !(st_d == ST_RUN && done_b);
         o_clk_stop_ok <= (st_d == ST_SR);
         case (st_d)
            ST_RUN: begin
               if (o_cmd_ready) begin
                  {o_cs_n, o_ras_n, o_cas_n, o_we_n} <= i_cmd;
               end
            end
            ST_SRE: begin
               if (st_q == ST_RUN) begin
                  o_cke <= 1'b0;
                  {o_cs_n, o_ras_n, o_cas_n, o_we_n} <= `DLP_CMD_SRE;
               end else begin
                  o_cke <= 1'b0;
               end
            end
            ST_SR: begin
               o_cke <= 1'b0;
            end
            ST_PDE: begin
               o_cke <= 1'b0;
            end
            ST_PD: begin
               o_cke <= 1'b0;
            end
            default: begin
               o_cke <= 1'b1;
            end
         endcase
      end
   end
endmodule

// ==== dlp_lowpower_chk.sv ====
// Checker of the low-power sequencer pin protocol.
`timescale 1ns/100ps
module dlp_lowpower_chk (
   input wire i_sys_clk, // Clock.
   input wire i_nrst, // Reset.
   input wire o_cke, // CKE.
   input wire o_cs_n, // Select.
   input wire o_ras_n, // Row.
   input wire o_cas_n, // Column.
   input wire o_we_n, // Write.
   input wire o_cmd_ready, // Taken.
   input wire o_clk_stop_ok, // Stop.
   input wire o_dll_reset_req, // DLL reset.
   input wire o_need_refresh // Owed.
);
   // Pin command and its NOP or deselect decode.
   wire [3:0] cmd = {o_cs_n, o_ras_n, o_cas_n, o_we_n};
   wire nop = (cmd == 4'h7) || o_cs_n;
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_nrst);
   sequence sr_in;
      $fell(o_cke) && cmd == 4'h1;
   endsequence
   sequence cke_up;
      $rose(o_cke) && $past(i_nrst);
   endsequence
   chk_entry_cmd: assert property (
      $fell(o_cke) |-> nop || cmd == 4'h1) else $error("bad entry command");
   chk_cpded_nop: assert property (
      $fell(o_cke) |=> nop) else $error("command during tCPDED");
   chk_cke_low: assert property (
      $fell(o_cke) |-> !o_cke [*3]) else $error("CKE low too short");
   chk_sr_stay: assert property (
      sr_in |-> !o_cke [*4]) else $error("self-refresh too short");
   chk_cke_high: assert property (
      cke_up |-> o_cke [*3]) else $error("CKE high too short");
   chk_exit_nop: assert property (
      cke_up |-> nop [*3]) else $error("command during exit");
   chk_clk_stop: assert property (
      o_clk_stop_ok |-> !o_cke && !$past(o_cke)) else $error("clock stop");
   chk_ready_wait: assert property (
      o_cmd_ready && $past(i_nrst, 3) |-> o_cke && $past(o_cke, 3))
      else $error("command before exit wait");
   chk_dll_pulse: assert property (
      $rose(o_dll_reset_req) |-> o_cke ##1 !o_dll_reset_req)
      else $error("DLL reset pulse");
   chk_ref_first: assert property (
      sr_in |-> !$past(o_need_refresh)) else $error("re-entry unrefreshed");
endmodule
bind dlp_lowpower_ctrl dlp_lowpower_chk u_chk (.i_sys_clk, .i_nrst,
   .o_cke, .o_cs_n, .o_ras_n, .o_cas_n, .o_we_n, .o_cmd_ready,
   .o_clk_stop_ok, .o_dll_reset_req, .o_need_refresh);

// ==== dlp_dev_model.sv ====
// Behavioural DDR3 device that tracks its low-power states.
`timescale 1ns/100ps
module dlp_dev_model #(
   parameter T_CKE = 3, // Shortest CKE level.
   parameter T_CKESR = 4, // Shortest self-refresh.
   parameter FAST_PD = 1 // Mode bit for fast exit; banks stay closed.
) (
   input wire i_ck, // Memory clock.
   input wire i_reset_n, // Device reset, active low.
   input wire i_cke, // CKE pin.
   input wire [3:0] i_cmd, // Pins {cs_n, ras_n, cas_n, we_n}.
   output reg o_in_sr, // In self-refresh.
   output reg o_in_pd, // In power-down.
   output reg o_dll_on, // DLL running.
   output reg [7:0] o_refs, // Internal refreshes.
   output reg [7:0] o_bad // Faults seen.
);
   reg [7:0] lvl_q; // Edges since CKE changed, saturating.
   reg cke_q; // CKE at the previous edge.
   wire nop = (i_cmd == 4'h7) || i_cmd[3]; // NOP or deselect.
   wire flip = i_cke != cke_q; // CKE changes at this edge.
   // Reset also drops the device out of power-down.
   always @(posedge i_ck or negedge i_reset_n) begin
      if (!i_reset_n) begin
         {o_in_sr, o_in_pd, cke_q, o_dll_on} <= 4'h1;
         {o_refs, o_bad, lvl_q} <= {8'h00, 8'h00, 8'hFF};
      end else begin
         cke_q <= i_cke;
         lvl_q <= flip ? 8'h01 : lvl_q + {7'h00, ~&lvl_q};
         if (flip && lvl_q < T_CKE) o_bad <= o_bad + 8'h01;
         if (o_in_sr) begin
            if (lvl_q == 8'h01) o_refs <= o_refs + 8'h01;
            if (i_cke) begin
               {o_in_sr, o_dll_on} <= 2'h1;
               if (lvl_q < T_CKESR) o_bad <= o_bad + 8'h01;
            end
         end else if (o_in_pd) begin
            if (lvl_q == 8'h01 && !nop) o_bad <= o_bad + 8'h01;
            if (i_cke) {o_in_pd, o_dll_on} <= 2'h1;
         end else if (flip && !i_cke) begin
            if (i_cmd == 4'h1) begin
               {o_in_sr, o_dll_on} <= 2'h2;
            end else begin
               {o_in_pd, o_dll_on} <= {1'b1, FAST_PD[0]};
               if (!nop) o_bad <= o_bad + 8'h01;
            end
         end
      end
   end
endmodule

// ==== tb_dlp_lowpower_ctrl.sv ====
// Self-checking bench for the low-power sequencer.
`timescale 1ns/100ps
module tb_dlp_lowpower_ctrl;
   reg clk = 1'b0; // Clock.
   reg nrst = 1'b0; // Reset.
   reg sr = 1'b0, pd = 1'b0, idle = 1'b1, busy = 1'b0; // Requests.
   reg odt = 1'b1, dllu = 1'b0, stab = 1'b1, cv = 1'b0; // Qualifiers.
   reg [3:0] cmd = 4'h7; // Command.
   reg slw = 1'b0, vrf = 1'b0, rr = 1'b0, wr = 1'b0, nd = 1'b0; // Modes.
   wire rdy, cke, cs_n, ras_n, cas_n, we_n, odtn, ckok, dllr, nref;
   wire isr, ipd, m_sr, m_pd, m_dll; // State flags.
   wire [7:0] m_refs, m_bad; // Model counters.
   wire [3:0] pins = {cs_n, ras_n, cas_n, we_n}; // Pin command.
   integer n_errors = 0; // Mismatches.
   integer n_tests = 0; // Comparisons.
   always #50 clk = ~clk;
   dlp_lowpower_ctrl #(.T_XSDLL(16'h0010), .T_VREF(16'h0010),
      .PD_MAX(32'h00000040)) u_dut (.i_sys_clk(clk), .i_nrst(nrst),
      .i_sr_req(sr), .i_pd_req(pd), .i_idle(idle), .i_busy(busy),
      .i_odt_off(odt), .i_slow_exit(slw), .i_dll_unlocked(dllu),
      .i_vref_float(vrf), .i_ref_recent(rr), .i_clk_stable(stab),
      .i_cmd_valid(cv), .i_cmd(cmd), .i_cmd_is_wr(wr),
      .i_cmd_need_dll(nd), .o_cmd_ready(rdy), .o_cke(cke),
      .o_cs_n(cs_n), .o_ras_n(ras_n), .o_cas_n(cas_n), .o_we_n(we_n),
      .o_odt_en_n(odtn), .o_clk_stop_ok(ckok), .o_dll_reset_req(dllr),
      .o_need_refresh(nref), .o_in_sr(isr), .o_in_pd(ipd));
   dlp_dev_model u_dev (.i_ck(clk), .i_reset_n(nrst), .i_cke(cke),
      .i_cmd(pins), .o_in_sr(m_sr), .o_in_pd(m_pd), .o_dll_on(m_dll),
      .o_refs(m_refs), .o_bad(m_bad));
   task chk(input bit c, input string m);
      begin
         n_tests = n_tests + 1;
         if (!c) begin
            n_errors = n_errors + 1;
            $display("[FAIL] %0t %s", $time, m);
         end
      end
   endtask
   task cyc(input integer n);
      repeat (n) @(negedge clk);
   endtask
   // Waits for a CKE level; a timeout ends the run.
   task wait_cke(input bit v);
      integer k;
      begin
         k = 0;
         while (cke !== v && k < 200) begin
            @(negedge clk);
            k = k + 1;
         end
         chk(cke === v, "CKE wait timed out");
         if (k == 200) end_sim;
      end
   endtask
   // Offers a command until taken, then checks it on the pins.
   task send(input [3:0] c);
      integer k;
      begin
         cv = 1'b1;
         cmd = c;
         k = 0;
         while (rdy !== 1'b1 && k < 50) begin
            @(negedge clk);
            k = k + 1;
         end
         cyc(1);
         cv = 1'b0;
         chk(pins === c, "command pins");
         cyc(1);
         if (k == 50) end_sim;
      end
   endtask
   task t_sr;
      begin
         idle = 1'b0;
         sr = 1'b1;
         cyc(6);
         chk(cke === 1'b1, "entry while busy");
         idle = 1'b1;
         odt = 1'b0;
         cyc(6);
         chk(cke === 1'b1, "entry with ODT on");
         odt = 1'b1;
         wait_cke(1'b0);
         chk(pins === 4'h1, "entry pattern");
         cyc(2);
         chk({m_sr, isr, ckok} === 3'h7, "self-refresh state");
         stab = 1'b0;
         sr = 1'b0;
         cyc(12);
         chk(cke === 1'b0, "exit on unstable clock");
         stab = 1'b1;
         wait_cke(1'b1);
         cyc(5);
         chk({odtn, nref} === 2'h3, "exit flags");
         chk(m_bad === 8'h00 && m_refs !== 8'h00, "device");
         sr = 1'b1;
         cyc(8);
         chk(cke === 1'b1, "re-entry unrefreshed");
         sr = 1'b0;
         send(4'h1);
         chk(nref === 1'b0, "refresh still owed");
         sr = 1'b1;
         wait_cke(1'b0);
         sr = 1'b0;
         wait_cke(1'b1);
      end
   endtask
   task t_pd;
      integer k;
      begin
         busy = 1'b1;
         pd = 1'b1;
         cyc(6);
         chk(cke === 1'b1, "drop while busy");
         busy = 1'b0;
         dllu = 1'b1;
         wait_cke(1'b0);
         chk(pins[3] === 1'b1 || pins === 4'h7, "entry command");
         cyc(2);
         chk({m_pd, ipd, m_dll} === 3'h7, "pd state");
         pd = 1'b0;
         wait_cke(1'b1);
         chk(rdy === 1'b0, "command too early");
         k = 0;
         while (dllr !== 1'b1 && k < 10) begin
            @(negedge clk);
            k = k + 1;
         end
         chk(dllr === 1'b1, "no DLL reset");
         dllu = 1'b0;
      end
   endtask
   task t_pdmax;
      integer k;
      begin
         pd = 1'b1;
         slw = 1'b1;
         wait_cke(1'b0);
         k = 0;
         while (cke === 1'b0 && k < 100) begin
            @(negedge clk);
            k = k + 1;
         end
         pd = 1'b0;
         chk(k > 64 && k <= 68, "power-down residency");
         wait_cke(1'b1);
         cyc(6);
         chk(odtn === 1'b1, "ODT open before tXPDLL");
         slw = 1'b0;
      end
   endtask
   // Prints the counts and the verdict, then stops.
   task end_sim;
      begin
         $display("errors %0d checks %0d", n_errors, n_tests);
         if (n_errors == 0 && n_tests > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   initial begin
      cyc(5);
      nrst = 1'b1;
      cyc(4);
      t_sr;
      cyc(4);
      t_pd;
      cyc(4);
      t_pdmax;
      cyc(4);
      chk(m_bad === 8'h00, "device faults");
      end_sim;
   end
endmodule
